// *** hw/cfb_branch_exec.sv ***
`timescale 1ns/1ps
// Functional notes
// RULE1: the overflow branch redirects to the relative target only when the overflow flag is one.
// RULE2: the zero branch redirects to the relative target only when the zero flag is one.
// RULE3: the offset byte is signed, -128 to 127, and doubled into a byte displacement.
// RULE4: a taken target is the branch's own address plus 2 plus twice the offset.
// RULE5: a taken branch takes two cycles, the second an idle cycle with no operation.
// RULE6: an untaken branch finishes in one cycle and never writes the counter.
// RULE7: the target is based on the counter at the branch start plus the sequential step.
// RULE8: each branch is one 16-bit word, opcode in the upper byte, offset low, flags untouched.
//
// timing of one issue, counted in clock edges from the edge that takes the word:
//   edge 0: instr.valid high with a branch opcode while the unit is not in its bubble
//   edge 1: done pulses for every branch; pc_we, flush and busy pulse only when taken
//   edge 2: a taken branch is back in the execute state and takes a new word again
// untaken branches may follow each other on every edge, one done pulse apiece.
// a word offered while busy is high is dropped without any answer: the fetch side
// must discard the prefetched word anyway, so no queue is kept for it.
// pc_new keeps the last target between branches, so the counter side may read it
// at any time, but it is only meaningful in the cycle in which pc_we stands.
// flags are sampled with the word at edge 0; a flag that changes in the bubble has
// no effect on the branch already in flight.
// the target wraps modulo the counter width, like the sequential fetch step does.
//
module cfb_branch_exec
  import cfb_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input cfb_pkg::cfb_instr_t instr,
  input cfb_pkg::cfb_flags_t flags,
  output cfb_pkg::cfb_result_t result,
  output logic busy
);
  typedef enum logic {
    CFB_EXEC,
    CFB_BUBBLE
  } cfb_state_t;

  cfb_state_t state_q, state_d;
  cfb_result_t result_q, result_d;
  logic busy_q, busy_d;
  cfb_op_t op;
  logic [PC_W-1:0] target;
  logic take;
  logic is_branch;

  cfb_decode u_dec (
    .word(instr.word),
    .addr(instr.addr),
    .op(op),
    .target(target)
  );

  // flag test; flags are only read, never written, by this unit
  always_comb begin
    case (op)
      CFB_OP_OVERFLOW: take = flags.overflow; // see RULE1
      CFB_OP_ZERO: take = flags.zero; // see RULE2
      default: take = 1'b0;
    endcase
    is_branch = instr.valid && (op != CFB_OP_NONE);
  end

  // issue is ignored during the bubble: the prefetched word is discarded
  always_comb begin
    state_d = state_q;
    busy_d = 1'b0;
    result_d = '0;
    result_d.pc_new = result_q.pc_new;
    case (state_q)
      CFB_EXEC: begin
        if (is_branch) begin
          result_d.done = 1'b1;
          if (take) begin
            result_d.pc_we = 1'b1; // see RULE4
            result_d.pc_new = target;
            result_d.flush = 1'b1;
            state_d = CFB_BUBBLE; // see RULE5
          end
          // untaken: done only, counter keeps its sequential value, see RULE6
        end
      end
      CFB_BUBBLE: begin
        state_d = CFB_EXEC; // second cycle is a no operation, see RULE5
      end
      default: state_d = CFB_EXEC;
    endcase
    // busy is registered so the output comes straight from a flop, see RULE5
    busy_d = (state_d == CFB_BUBBLE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CFB_EXEC;
      result_q <= '0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      result_q <= result_d;
      busy_q <= busy_d;
    end
  end

  // outputs come straight from flops
  assign result = result_q;
  assign busy = busy_q;

  // checks: taken and untaken answers one edge after the issue
  a_ovf_taken: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && op == CFB_OP_OVERFLOW && flags.overflow
    |=> result.pc_we && result.pc_new == $past(instr.addr) + PC_STEP
        + PC_W'(signed'({{(PC_W-8){$past(instr.word[7])}}, $past(instr.word[7:0])}) <<< 1))
    else $error("overflow branch target wrong"); // see RULE1
  a_zero_taken: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && op == CFB_OP_ZERO && flags.zero |=> result.pc_we)
    else $error("zero branch not taken"); // see RULE2
  a_ovf_clear: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && op == CFB_OP_OVERFLOW && !flags.overflow
    |=> !result.pc_we && result.done)
    else $error("overflow branch taken with flag clear"); // see RULE1
  a_untaken_nowr: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && !take |=> !result.pc_we && !busy)
    else $error("untaken branch wrote counter"); // see RULE6
  a_taken_bubble: assert property (@(posedge clk) disable iff (!arst_n)
    result.pc_we |-> busy ##1 (!busy && !result.done))
    else $error("taken branch bubble wrong"); // see RULE5
  a_offset_neg: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && take && instr.word[7:0] == 8'h80
    |=> result.pc_new == $past(instr.addr) - 21'h0000fe)
    else $error("min offset target wrong"); // see RULE3
  a_offset_pos: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && take && instr.word[7:0] == 8'h7f
    |=> result.pc_new == $past(instr.addr) + 21'h000100)
    else $error("max offset target wrong"); // see RULE4
  a_other_op: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && !is_branch |=> !result.done && !result.pc_we)
    else $error("non-branch word acted on"); // see RULE8
  a_base_addr: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && take && instr.word[7:0] == 8'h00
    |=> result.pc_new == $past(instr.addr) + PC_STEP)
    else $error("zero offset target wrong"); // see RULE7

  // zero branch with its flag clear only reports completion
  a_zero_clear: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && op == CFB_OP_ZERO && !flags.zero
    |=> !result.pc_we && result.done)
    else $error("zero branch taken with flag clear"); // see RULE2

  // zero branch target worked out independently of the decoder
  a_zero_target: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && op == CFB_OP_ZERO && flags.zero
    |=> result.pc_new == $past(instr.addr) + PC_STEP
        + PC_W'(signed'({{(PC_W-8){$past(instr.word[7])}}, $past(instr.word[7:0])}) <<< 1))
    else $error("zero branch target wrong"); // see RULE4

  // an offset of minus one lands back on the branch itself
  a_offset_m1: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && take && instr.word[7:0] == 8'hff
    |=> result.pc_new == $past(instr.addr))
    else $error("minus one offset target wrong"); // see RULE3

  // flush always travels with the counter write
  a_flush_pair: assert property (@(posedge clk) disable iff (!arst_n)
    result.flush == result.pc_we)
    else $error("flush without counter write"); // see RULE5

  // a counter write is always a completed branch
  a_taken_done: assert property (@(posedge clk) disable iff (!arst_n)
    result.pc_we |-> result.done)
    else $error("counter write without done"); // see RULE5

  // busy stands only in the cycle of the write, never longer
  a_busy_write: assert property (@(posedge clk) disable iff (!arst_n)
    busy |-> result.pc_we)
    else $error("busy without counter write"); // see RULE5
  a_busy_single: assert property (@(posedge clk) disable iff (!arst_n)
    busy |=> !busy)
    else $error("busy longer than one cycle"); // see RULE5

  // a word offered in the bubble gets no answer
  a_bubble_refuse: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_BUBBLE |=> !result.done && !result.pc_we)
    else $error("word acted on during bubble"); // see RULE5

  // the target output holds whenever no write is made
  a_untaken_hold: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && !take |=> $stable(result.pc_new))
    else $error("untaken branch moved target"); // see RULE6
  a_pc_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !result_d.pc_we |=> $stable(result.pc_new))
    else $error("target changed without write"); // see RULE6

  c_ovf_taken: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && op == CFB_OP_OVERFLOW && take);
  c_zero_taken: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && op == CFB_OP_ZERO && take);
  c_untaken: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_EXEC && is_branch && !take);
  c_back_to_back: cover property (@(posedge clk) disable iff (!arst_n)
    result.pc_we ##2 result.pc_we);
  c_refused: cover property (@(posedge clk) disable iff (!arst_n)
    state_q == CFB_BUBBLE && instr.valid);
endmodule

// *** hw/cfb_pkg.sv ***
package cfb_pkg;
  // program counter width, 21-bit byte address space
  localparam int unsigned PC_W = 21;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  // sequential fetch step in bytes (one instruction word)
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // opcode and offset byte positions in the instruction word
  localparam int unsigned OPC_HI = 15;
  localparam int unsigned OPC_LO = 8;
  localparam int unsigned OFS_HI = 7;
  localparam int unsigned OFS_LO = 0;
  localparam logic [7:0] OPC_BRANCH_ON_OVERFLOW = 8'he4;
  localparam logic [7:0] OPC_BRANCH_ON_ZERO = 8'he0;
  // shift that doubles a word offset into a byte displacement
  localparam int unsigned OFS_SHIFT = 1;

  typedef enum logic [1:0] {
    CFB_OP_NONE,
    CFB_OP_OVERFLOW,
    CFB_OP_ZERO
  } cfb_op_t;

  // one issued instruction from fetch/decode
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [PC_W-1:0] addr;
  } cfb_instr_t;

  // status flags seen by the branch unit
  typedef struct packed {
    logic overflow;
    logic zero;
  } cfb_flags_t;

  // result toward the program counter logic
  typedef struct packed {
    logic pc_we;
    logic [PC_W-1:0] pc_new;
    logic flush;
    logic done;
  } cfb_result_t;
endpackage

// *** hw/cfb_decode.sv ***
`timescale 1ns/1ps
// pure opcode and target decode for one instruction word
module cfb_decode
  import cfb_pkg::*;
(
  input wire logic [15:0] word,
  input wire logic [cfb_pkg::PC_W-1:0] addr,
  output cfb_pkg::cfb_op_t op,
  output logic [cfb_pkg::PC_W-1:0] target
);
  logic [7:0] opc;
  logic signed [7:0] ofs;
  logic [PC_W-1:0] disp;

  // upper byte selects the branch, lower byte is the offset
  always_comb begin
    opc = word[OPC_HI:OPC_LO]; // see RULE8
    ofs = word[OFS_HI:OFS_LO];
    case (opc)
      OPC_BRANCH_ON_OVERFLOW: op = CFB_OP_OVERFLOW; // see RULE8
      OPC_BRANCH_ON_ZERO: op = CFB_OP_ZERO; // see RULE8
      default: op = CFB_OP_NONE;
    endcase
  end

  // sign-extend then double; wraps modulo the address space like the real counter
  always_comb begin
    disp = PC_W'(signed'({{(PC_W-8){ofs[7]}}, ofs}) <<< OFS_SHIFT); // see RULE3
    target = addr + PC_STEP + disp; // see RULE4, see RULE7
  end
endmodule

// *** bench/cfb_fetch_model.sv ***
`timescale 1ns/1ps
// counter side of the core: loads a branch target only when told to
module cfb_fetch_model
  import cfb_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input cfb_pkg::cfb_result_t result,
  output logic [cfb_pkg::PC_W-1:0] pc_q
);
  // untaken branches leave the counter alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pc_q <= PC_RESET;
    else if (result.pc_we) pc_q <= result.pc_new;
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import cfb_pkg::*;
  logic clk, arst_n, busy;
  cfb_instr_t instr;
  cfb_flags_t flags;
  cfb_result_t result;
  logic [PC_W-1:0] pc;
  int n_mismatch = 0;
  int check_count = 0;
  cfb_branch_exec u_dut (.clk(clk), .arst_n(arst_n), .instr(instr), .flags(flags),
    .result(result), .busy(busy));
  cfb_fetch_model u_fetch (.clk(clk), .arst_n(arst_n), .result(result), .pc_q(pc));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // issue one word, judge the answer edge and the bubble edge after it
  task automatic run(input logic [7:0] opc, input logic [7:0] ofs,
      input logic [PC_W-1:0] a, input logic ov, input logic z);
    logic br, tk;
    logic [PC_W-1:0] exp_t, pc0;
    br = (opc == OPC_BRANCH_ON_OVERFLOW) || (opc == OPC_BRANCH_ON_ZERO);
    tk = br && ((opc == OPC_BRANCH_ON_OVERFLOW) ? ov : z);
    exp_t = a + PC_STEP + {{12{ofs[7]}}, ofs, 1'b0};
    pc0 = pc;
    @(posedge clk);
    instr <= '{valid: 1'b1, word: {opc, ofs}, addr: a};
    flags <= '{overflow: ov, zero: z};
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
    `CHK(result.done, br)
    `CHK(result.pc_we, tk)
    `CHK(result.flush, tk)
    `CHK(busy, tk)
    if (tk) `CHK(result.pc_new, exp_t)
    @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
    `CHK(pc, tk ? exp_t : pc0)
  endtask
  task automatic t_overflow();
    run(OPC_BRANCH_ON_OVERFLOW, 8'h80, 21'h001000, 1'b1, 1'b0);
    run(OPC_BRANCH_ON_OVERFLOW, 8'h7f, 21'h001000, 1'b0, 1'b1);
    run(OPC_BRANCH_ON_OVERFLOW, 8'h7f, 21'h1ffffe, 1'b1, 1'b1);
  endtask
  task automatic t_zero();
    run(OPC_BRANCH_ON_ZERO, 8'hff, 21'h000400, 1'b0, 1'b1);
    run(OPC_BRANCH_ON_ZERO, 8'h01, 21'h000400, 1'b1, 1'b0);
    run(8'he8, 8'h05, 21'h000400, 1'b1, 1'b1);
  endtask
  // a second branch issued into the bubble must be dropped
  task automatic t_refuse();
    @(posedge clk);
    instr <= '{valid: 1'b1, word: {OPC_BRANCH_ON_ZERO, 8'h10}, addr: 21'h000100};
    flags <= '{overflow: 1'b1, zero: 1'b1};
    @(posedge clk);
    instr.word <= {OPC_BRANCH_ON_OVERFLOW, 8'h20};
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
    `CHK(result.done, 1'b0)
    `CHK(pc, 21'h000122)
  endtask
  // main sequence
  initial begin
    arst_n = 1'b0;
    instr = '0;
    flags = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    `CHK(result.pc_new, PC_RESET)
    t_overflow();
    t_zero();
    t_refuse();
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
